// ---- disk_cmd_cfg.svh ----
// named constants for the disk command ends
// assumes inclusion by bare name from the controller end and the host end
`ifndef DISK_CMD_CFG_SVH
`define DISK_CMD_CFG_SVH
`define EXT_BYTES        11'h006
`define ID_LAST          11'h004
`define ID_BYTES         32'h00000005
`define KIND_NORMAL      8'h00
`define KIND_ALT         8'h40
`define KIND_DEFECT      8'h80
`define DEFECT_TAG       8'h0c
`define CODE_NORMAL      2'h0
`define CODE_ALT         2'h1
`define CODE_DEFECT      2'h2
`define MOD_EXT          7
`define MOD_DIRECT       6
`define MOD_WORD         5
`define MOD_DELETED      2
`define MOD_NORETRY      1
`define MOD_NOIRQ        0
`define MOD_RSVD_MASK    8'h18
`define SEC_LEN_BASE     11'h080
`define FIRST_SEC_FLOPPY 8'h01
`define FIRST_SEC_HARD   8'h00
`define ST_DISK_ERR      0
`define ST_OVERRUN       1
`define ST_BAD_TRACK     2
`define SLOT_COUNT       64
`define BUF_BYTES        1024
`endif

// ---- disk_cmd_pkg.sv ----
// shared types of the disk command ends
// assumes nothing of its surroundings
package disk_cmd_pkg;
  typedef enum logic [1:0] {
    OP_FORMAT  = 2'h0,
    OP_READ_ID = 2'h1,
    OP_READ    = 2'h2,
    OP_VERIFY  = 2'h3
  } cmd_op_e;
  typedef enum logic [7:0] {
    S_IDLE  = 8'h01,
    S_FETCH = 8'h02,
    S_ORDER = 8'h04,
    S_FMT   = 8'h08,
    S_RDID  = 8'h10,
    S_RDSEC = 8'h20,
    S_DRAIN = 8'h40,
    S_DONE  = 8'h80
  } ctrl_state_e;
endpackage

// ---- disk_cmd_if.sv ----
// link between the host end and the controller end
// assumes one shared clock; the testbench joins the two ends
`timescale 1ns/1ns
`default_nettype none
interface disk_cmd_if (
  input wire logic clk
);
  // command request, held until taken
  logic                    cmd_valid;
  logic                    cmd_ready;
  disk_cmd_pkg::cmd_op_e   cmd_op;
  logic [7:0]              cmd_mod;
  logic [15:0]             cmd_cyl;
  logic [7:0]              cmd_head;
  logic [7:0]              cmd_sec;
  logic [31:0]             cmd_count;
  // parameter extension fetch, answered one cycle later
  logic                    ext_req;
  logic [2:0]              ext_idx;
  logic                    ext_valid;
  logic [7:0]              ext_data;
  // writes into host memory
  logic                    mem_valid;
  logic                    mem_ready;
  logic [31:0]             mem_addr;
  logic [15:0]             mem_data;
  logic                    mem_word;
  logic                    bus_lock;
  // completion
  logic                    done;
  logic                    irq;
  logic [7:0]              status;
  logic [31:0]             actual;
  modport device (
    input  clk, cmd_valid, cmd_op, cmd_mod, cmd_cyl, cmd_head, cmd_sec,
    input  cmd_count, ext_valid, ext_data, mem_ready,
    output cmd_ready, ext_req, ext_idx, mem_valid, mem_addr, mem_data,
    output mem_word, bus_lock, done, irq, status, actual
  );
  modport host (
    input  clk, cmd_ready, ext_req, ext_idx, mem_valid, mem_addr, mem_data,
    input  mem_word, bus_lock, done, irq, status, actual,
    output cmd_valid, cmd_op, cmd_mod, cmd_cyl, cmd_head, cmd_sec,
    output cmd_count, ext_valid, ext_data, mem_ready
  );
endinterface
`default_nettype wire

// ---- disk_ctrl_end.sv ----
// controller end: format, read sector id, read data, read and verify
// assumes a drive model on the disk ports and the host end on bus
// Overview of operation
// - format writes ids and pattern over one track
// - six byte format extension fetched from host
// - first extension byte selects normal, alternate, defective
// - host sends zero track type for floppies
// - floppy repeats byte one, hard repeats four
// - defective pattern holds alternate address, tag 0ch
// - interleave sets spacing between consecutive sectors
// - lowest sector follows index: floppy 1, hard 0
// - read id: no seek, current track
// - five id bytes written to host buffer
// - two-bit track kind and length codes
// - read copies count bytes, reports actual count
// - buffered mode reads whole sector before moving
// - continue next head, then next cylinder head 0
// - partial last sector read whole, partly moved
// - modifier bit 7 gates bits 6 and 5
// - bit 6 direct hard transfers, bus lock held
// - bit 5 forces word transfers, except in read id
// - bit 2 floppy deleted marks, 1 no retry, 0 no irq
// - host keeps modifier bits 4 and 3 zero
// - verify reads to buffer, sends nothing
// - verify rounds count up to whole sectors
// - sector length is 128, 256, 512 or 1024
`timescale 1ns/1ns
`default_nettype none
`include "disk_cmd_cfg.svh"
module disk_ctrl_end (
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  disk_cmd_if.device       bus,
  input  wire logic        bus_width_jumper_i,
  input  wire logic        buffer_mode_jumper_a_i,
  input  wire logic        buffer_mode_jumper_b_i,
  input  wire logic        floppy_i,
  input  wire logic [1:0]  sector_length_code_i,
  input  wire logic [5:0]  spt_i,
  input  wire logic [7:0]  heads_i,
  output logic             dk_req_o,
  output logic             dk_id_only_o,
  output logic             dk_seek_o,
  output logic [15:0]      dk_cyl_o,
  output logic [7:0]       dk_head_o,
  output logic [7:0]       dk_sec_o,
  output logic             dk_deleted_o,
  output logic             dk_noretry_o,
  input  wire logic        dk_valid_i,
  input  wire logic [7:0]  dk_data_i,
  input  wire logic        dk_err_i,
  output logic             fw_valid_o,
  output logic             fw_mark_o,
  output logic [1:0]       track_kind_code_o,
  output logic [7:0]       fw_data_o,
  input  wire logic        fw_ready_i
);
  disk_cmd_pkg::ctrl_state_e state_reg;
  disk_cmd_pkg::cmd_op_e     op_reg;
  logic [7:0]  mod_reg;
  logic [15:0] cyl_reg;
  logic [7:0]  head_reg;
  logic [7:0]  sec_reg;
  logic [31:0] rem_reg;
  logic [31:0] act_reg;
  logic [47:0] ext_reg;
  logic [10:0] cnt_reg;
  logic [5:0]  pos_reg;
  logic [5:0]  slot_reg;
  logic [63:0] taken_reg;
  logic        req_pend_reg;
  logic        seek_reg;
  logic        wait_reg;
  logic [7:0]  status_reg;
  logic [31:0] addr_reg;
  logic [7:0]  lo_reg;
  logic        have_reg;
  logic        out_v_reg;
  logic        sp_v_reg;
  logic [48:0] sp_reg;
  logic [5:0]  order_mem [`SLOT_COUNT];
  logic [7:0]  sbuf_mem [`BUF_BYTES];

  // mode decode from modifier and jumpers
  wire logic        st_idle = state_reg == disk_cmd_pkg::S_IDLE;
  wire logic        st_rdid = state_reg == disk_cmd_pkg::S_RDID;
  wire logic        st_rdsec = state_reg == disk_cmd_pkg::S_RDSEC;
  wire logic        st_drain = state_reg == disk_cmd_pkg::S_DRAIN;
  wire logic        is_read = op_reg == disk_cmd_pkg::OP_READ;
  wire logic        is_verify = op_reg == disk_cmd_pkg::OP_VERIFY;
  wire logic        is_ext = mod_reg[`MOD_EXT];
  wire logic        jmp_direct = buffer_mode_jumper_a_i
                                 & ~buffer_mode_jumper_b_i;
  wire logic        direct = ~floppy_i
                             & ((is_ext & mod_reg[`MOD_DIRECT]) | jmp_direct);
  wire logic        word_mode = (bus_width_jumper_i
                                 | (is_ext & mod_reg[`MOD_WORD])) & ~st_rdid;
  wire logic [10:0] sec_len = `SEC_LEN_BASE << sector_length_code_i;
  wire logic [10:0] sec_last = sec_len - 11'h001;
  wire logic [7:0]  first_sec = floppy_i ? `FIRST_SEC_FLOPPY
                                         : `FIRST_SEC_HARD;
  wire logic [7:0]  last_sec = first_sec + {2'h0, spt_i} - 8'h01;

  // track kind and pattern decode of the fetched extension
  wire logic [7:0]  kind_byte = ext_reg[7:0];
  wire logic        kind_ok = kind_byte == `KIND_NORMAL
                              | kind_byte == `KIND_ALT
                              | kind_byte == `KIND_DEFECT;
  wire logic [1:0]  kind_code = kind_byte == `KIND_ALT ? `CODE_ALT
                              : kind_byte == `KIND_DEFECT ? `CODE_DEFECT
                              : `CODE_NORMAL;
  wire logic        tag_ok = kind_byte != `KIND_DEFECT | floppy_i
                             | ext_reg[39:32] == `DEFECT_TAG;
  wire logic [1:0]  pidx = cnt_reg[1:0] - 2'h1;
  wire logic [31:0] pats = ext_reg[39:8];
  wire logic [7:0]  pat = floppy_i ? ext_reg[15:8]
                                   : pats[{pidx, 3'h0} +: 8];
  wire logic [5:0]  ilv = ext_reg[45:40] == 6'h00 ? 6'h01 : ext_reg[45:40];

  // slot stepping for the interleave table
  wire logic [6:0]  step_sum = {1'b0, pos_reg} + {1'b0, ilv};
  wire logic [6:0]  step_wrap = step_sum >= {1'b0, spt_i}
                                ? step_sum - {1'b0, spt_i} : step_sum;
  wire logic [5:0]  pos_inc = pos_reg + 6'h01;
  wire logic [5:0]  free_pos = pos_inc == spt_i ? 6'h00 : pos_inc;
  wire logic        slot_busy = taken_reg[pos_reg];
  wire logic        order_full = cnt_reg[5:0] == spt_i;

  // byte producer toward host memory and the pair stage
  wire logic        live_v = dk_valid_i & rem_reg != 32'h0
                             & (st_rdid | (st_rdsec & direct & is_read));
  wire logic        drain_v = st_drain & rem_reg != 32'h0;
  wire logic        pb_v = live_v | drain_v;
  wire logic [7:0]  pb_d = drain_v ? sbuf_mem[cnt_reg[9:0]] : dk_data_i;
  wire logic        pb_last = rem_reg == 32'h1;
  wire logic        in_ready = ~sp_v_reg;
  wire logic        take = pb_v & in_ready;
  wire logic        push = take & (~word_mode | have_reg | pb_last);
  wire logic        overrun = live_v & ~in_ready;
  wire logic [48:0] push_ent = {addr_reg, have_reg,
                                have_reg ? {pb_d, lo_reg} : {8'h00, pb_d}};
  wire logic        pop = out_v_reg & bus.mem_ready;

  // end of sector and advance to the next sector
  wire logic [31:0] rem_after = take ? rem_reg - 32'h1 : rem_reg;
  wire logic [31:0] len32 = {21'h0, sec_len};
  wire logic        sec_end = st_rdsec & dk_valid_i & ~dk_err_i
                              & cnt_reg == sec_last;
  wire logic        drain_end = take & st_drain
                                & (pb_last | cnt_reg == sec_last);
  wire logic        go_next = (sec_end & (is_verify ? rem_reg > len32
                               : direct & rem_after != 32'h0))
                              | (drain_end & ~pb_last);
  wire logic        head_wrap = head_reg == heads_i - 8'h01;
  wire logic        trk_wrap = sec_reg == last_sec;
  wire logic        flush_ok = ~out_v_reg & ~sp_v_reg & ~fw_valid_o;
  wire logic        start = st_idle & bus.cmd_valid & bus.cmd_ready;

  // table of sector index per slot and the sector buffer
  always_ff @(posedge core_clk_i) begin
    if (state_reg == disk_cmd_pkg::S_ORDER & ~order_full & ~slot_busy)
      order_mem[pos_reg] <= cnt_reg[5:0];
    if (st_rdsec & dk_valid_i)
      sbuf_mem[cnt_reg[9:0]] <= dk_data_i;
  end

  // disk position: latched at start, stepped after each sector but the last
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cyl_reg  <= 16'h0;
      head_reg <= 8'h0;
      sec_reg  <= 8'h0;
      seek_reg <= 1'b0;
    end else if (start) begin
      cyl_reg  <= bus.cmd_cyl;
      head_reg <= bus.cmd_head;
      sec_reg  <= bus.cmd_sec;
      seek_reg <= bus.cmd_op != disk_cmd_pkg::OP_READ_ID;
    end else if (go_next) begin
      sec_reg  <= trk_wrap ? first_sec : sec_reg + 8'h01;
      head_reg <= trk_wrap ? (head_wrap ? 8'h0 : head_reg + 8'h01)
                           : head_reg;
      cyl_reg  <= trk_wrap & head_wrap ? cyl_reg + 16'h1 : cyl_reg;
      seek_reg <= trk_wrap & head_wrap;
    end else if (dk_req_o) begin
      seek_reg <= 1'b0;
    end
  end

  // pair stage and two-entry buffer toward host memory
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_v_reg <= 1'b0;
      sp_v_reg  <= 1'b0;
      sp_reg    <= 49'h0;
      have_reg  <= 1'b0;
      lo_reg    <= 8'h0;
      addr_reg  <= 32'h0;
      {bus.mem_addr, bus.mem_word, bus.mem_data} <= 49'h0;
    end else begin
      if (start)
        addr_reg <= 32'h0;
      else if (push)
        addr_reg <= addr_reg + (have_reg ? 32'h2 : 32'h1);
      if (take & ~push)
        lo_reg <= pb_d;
      if (take)
        have_reg <= ~push;
      if (pop & sp_v_reg) begin
        {bus.mem_addr, bus.mem_word, bus.mem_data} <= sp_reg;
        sp_v_reg <= 1'b0;
      end else if (push & (~out_v_reg | pop)) begin
        {bus.mem_addr, bus.mem_word, bus.mem_data} <= push_ent;
        out_v_reg <= 1'b1;
      end else if (push) begin
        sp_reg   <= push_ent;
        sp_v_reg <= 1'b1;
      end else if (pop) begin
        out_v_reg <= 1'b0;
      end
    end
  end
  assign bus.mem_valid = out_v_reg;
  assign bus.ext_idx   = cnt_reg[2:0];

  // command sequencer
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= disk_cmd_pkg::S_IDLE;
      op_reg    <= disk_cmd_pkg::OP_FORMAT;
      {mod_reg, rem_reg, act_reg, ext_reg, cnt_reg} <= 131'h0;
      {pos_reg, slot_reg, taken_reg, status_reg} <= 84'h0;
      {req_pend_reg, wait_reg, dk_req_o, dk_id_only_o} <= 4'h0;
      {dk_seek_o, dk_cyl_o, dk_head_o, dk_sec_o} <= 33'h0;
      {dk_deleted_o, dk_noretry_o, fw_valid_o, fw_mark_o} <= 4'h0;
      {track_kind_code_o, fw_data_o} <= 10'h0;
      {bus.ext_req, bus.done, bus.irq, bus.bus_lock} <= 4'h0;
      bus.cmd_ready <= 1'b1;
      bus.status    <= 8'h0;
      bus.actual    <= 32'h0;
    end else begin
      dk_req_o    <= 1'b0;
      bus.ext_req <= 1'b0;
      bus.done    <= 1'b0;
      bus.irq     <= 1'b0;
      if (fw_ready_i)
        fw_valid_o <= 1'b0;
      if (overrun)
        status_reg[`ST_OVERRUN] <= 1'b1;
      if (take) begin
        rem_reg <= rem_reg - 32'h1;
        act_reg <= act_reg + 32'h1;
      end
      if (go_next)
        req_pend_reg <= 1'b1;
      if (req_pend_reg & (st_rdsec | st_rdid)) begin
        req_pend_reg <= 1'b0;
        dk_req_o     <= 1'b1;
        dk_id_only_o <= st_rdid;
        dk_seek_o    <= seek_reg;
        {dk_cyl_o, dk_head_o, dk_sec_o} <= {cyl_reg, head_reg, sec_reg};
      end
      unique case (state_reg)
        disk_cmd_pkg::S_IDLE: if (start) begin
          bus.cmd_ready <= 1'b0;
          op_reg     <= bus.cmd_op;
          mod_reg    <= bus.cmd_mod;
          rem_reg    <= bus.cmd_count;
          act_reg    <= 32'h0;
          cnt_reg    <= 11'h0;
          status_reg <= 8'h0;
          taken_reg  <= 64'h0;
          pos_reg    <= 6'h0;
          wait_reg   <= 1'b0;
          req_pend_reg <= 1'b1;
          dk_deleted_o <= floppy_i & bus.cmd_mod[`MOD_DELETED];
          dk_noretry_o <= bus.cmd_mod[`MOD_NORETRY];
          bus.bus_lock <= bus.cmd_op == disk_cmd_pkg::OP_READ & ~floppy_i
                          & bus.cmd_mod[`MOD_EXT]
                          & bus.cmd_mod[`MOD_DIRECT];
          unique case (bus.cmd_op)
            disk_cmd_pkg::OP_FORMAT: state_reg <= disk_cmd_pkg::S_FETCH;
            disk_cmd_pkg::OP_READ_ID: begin
              rem_reg   <= `ID_BYTES;
              state_reg <= disk_cmd_pkg::S_RDID;
            end
            default: state_reg <= bus.cmd_count == 32'h0
                     ? disk_cmd_pkg::S_DONE : disk_cmd_pkg::S_RDSEC;
          endcase
        end
        disk_cmd_pkg::S_FETCH: if (cnt_reg == `EXT_BYTES) begin
          cnt_reg <= 11'h0;
          track_kind_code_o <= kind_code;
          if (kind_ok & tag_ok)
            state_reg <= disk_cmd_pkg::S_ORDER;
          else begin
            status_reg[`ST_BAD_TRACK] <= 1'b1;
            state_reg <= disk_cmd_pkg::S_DONE;
          end
        end else if (bus.ext_valid) begin
          ext_reg[{cnt_reg[2:0], 3'h0} +: 8] <= bus.ext_data;
          cnt_reg  <= cnt_reg + 11'h1;
          wait_reg <= 1'b0;
        end else if (~wait_reg) begin
          bus.ext_req <= 1'b1;
          wait_reg    <= 1'b1;
        end
        disk_cmd_pkg::S_ORDER: if (order_full) begin
          cnt_reg   <= 11'h0;
          slot_reg  <= 6'h0;
          state_reg <= disk_cmd_pkg::S_FMT;
        end else if (slot_busy) begin
          pos_reg <= free_pos;
        end else begin
          taken_reg[pos_reg] <= 1'b1;
          pos_reg <= step_wrap[5:0];
          cnt_reg <= cnt_reg + 11'h1;
        end
        disk_cmd_pkg::S_FMT: if (~fw_valid_o | fw_ready_i) begin
          fw_valid_o <= 1'b1;
          fw_mark_o  <= cnt_reg == 11'h0;
          fw_data_o  <= cnt_reg == 11'h0
                        ? first_sec + {2'h0, order_mem[slot_reg]} : pat;
          cnt_reg    <= cnt_reg + 11'h1;
          if (cnt_reg == sec_len) begin
            cnt_reg  <= 11'h0;
            slot_reg <= slot_reg + 6'h01;
            if (slot_reg == spt_i - 6'h01)
              state_reg <= disk_cmd_pkg::S_DONE;
          end
        end
        disk_cmd_pkg::S_RDID: if (dk_err_i) begin
          status_reg[`ST_DISK_ERR] <= 1'b1;
          state_reg <= disk_cmd_pkg::S_DONE;
        end else if (dk_valid_i) begin
          cnt_reg <= cnt_reg + 11'h1;
          if (cnt_reg == `ID_LAST)
            state_reg <= disk_cmd_pkg::S_DONE;
        end
        disk_cmd_pkg::S_RDSEC: if (dk_err_i) begin
          status_reg[`ST_DISK_ERR] <= 1'b1;
          state_reg <= disk_cmd_pkg::S_DONE;
        end else if (dk_valid_i) begin
          cnt_reg <= cnt_reg + 11'h1;
          if (sec_end) begin
            cnt_reg <= 11'h0;
            if (is_verify) begin
              act_reg <= act_reg + len32;
              rem_reg <= rem_reg > len32 ? rem_reg - len32 : 32'h0;
              if (rem_reg <= len32)
                state_reg <= disk_cmd_pkg::S_DONE;
            end else if (~direct)
              state_reg <= disk_cmd_pkg::S_DRAIN;
            else if (rem_after == 32'h0)
              state_reg <= disk_cmd_pkg::S_DONE;
          end
        end
        disk_cmd_pkg::S_DRAIN: if (take) begin
          cnt_reg <= cnt_reg + 11'h1;
          if (drain_end) begin
            cnt_reg   <= 11'h0;
            state_reg <= pb_last ? disk_cmd_pkg::S_DONE
                                 : disk_cmd_pkg::S_RDSEC;
          end
        end
        disk_cmd_pkg::S_DONE: if (flush_ok) begin
          bus.done      <= 1'b1;
          bus.irq       <= ~mod_reg[`MOD_NOIRQ];
          bus.status    <= status_reg;
          bus.actual    <= act_reg;
          bus.bus_lock  <= 1'b0;
          bus.cmd_ready <= 1'b1;
          state_reg     <= disk_cmd_pkg::S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- disk_host_end.sv ----
// host end: issues commands, answers extension fetches, takes writes
// assumes disk_ctrl_end on the far side of bus and a user memory port
`timescale 1ns/1ns
`default_nettype none
`include "disk_cmd_cfg.svh"
module disk_host_end (
  input  wire logic                   core_clk_i,
  input  wire logic                   rstn_i,
  disk_cmd_if.host                    bus,
  input  wire logic                   start_i,
  input  wire disk_cmd_pkg::cmd_op_e  op_i,
  input  wire logic [7:0]             mod_i,
  input  wire logic [15:0]            cyl_i,
  input  wire logic [7:0]             head_i,
  input  wire logic [7:0]             sec_i,
  input  wire logic [31:0]            count_i,
  input  wire logic [47:0]            ext_i,
  input  wire logic                   floppy_i,
  input  wire logic [31:0]            base_i,
  input  wire logic                   stall_i,
  output logic                        busy_o,
  output logic                        wr_en_o,
  output logic                        wr_word_o,
  output logic [31:0]                 wr_addr_o,
  output logic [15:0]                 wr_data_o,
  output logic                        done_o,
  output logic                        irq_o,
  output logic [7:0]                  status_o,
  output logic [31:0]                 actual_o
);
  logic [47:0] ext_reg;

  // extension image with the floppy track type forced to zero
  wire logic [47:0] ext_img = {ext_i[47:8],
                               floppy_i ? `KIND_NORMAL : ext_i[7:0]};
  wire logic        start = start_i & ~busy_o;
  wire logic        wr_take = bus.mem_valid & bus.mem_ready;

  // command issue, extension answers, memory writes, completion
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext_reg <= 48'h0;
      busy_o  <= 1'b0;
      {wr_en_o, wr_word_o, wr_addr_o, wr_data_o} <= 50'h0;
      {done_o, irq_o, status_o, actual_o} <= 42'h0;
      {bus.cmd_valid, bus.cmd_mod, bus.cmd_cyl} <= 25'h0;
      {bus.cmd_head, bus.cmd_sec, bus.cmd_count} <= 48'h0;
      bus.cmd_op    <= disk_cmd_pkg::OP_FORMAT;
      bus.ext_valid <= 1'b0;
      bus.ext_data  <= 8'h0;
      bus.mem_ready <= 1'b0;
    end else begin
      bus.ext_valid <= bus.ext_req;
      bus.ext_data  <= ext_reg[{bus.ext_idx, 3'h0} +: 8];
      bus.mem_ready <= ~stall_i;
      wr_en_o   <= wr_take;
      wr_word_o <= bus.mem_word;
      wr_addr_o <= base_i + bus.mem_addr;
      wr_data_o <= bus.mem_data;
      done_o    <= bus.done;
      irq_o     <= bus.done & bus.irq;
      if (bus.cmd_valid & bus.cmd_ready)
        bus.cmd_valid <= 1'b0;
      if (start) begin
        busy_o        <= 1'b1;
        ext_reg       <= ext_img;
        bus.cmd_valid <= 1'b1;
        bus.cmd_op    <= op_i;
        bus.cmd_mod   <= mod_i & ~`MOD_RSVD_MASK;
        bus.cmd_cyl   <= cyl_i;
        bus.cmd_head  <= head_i;
        bus.cmd_sec   <= sec_i;
        bus.cmd_count <= count_i;
      end else if (bus.done) begin
        busy_o   <= 1'b0;
        status_o <= bus.status;
        actual_o <= bus.actual;
      end
    end
  end
endmodule
`default_nettype wire

// ---- disk_link_monitor.sv ----
// checker on the link between the two disk command ends
// assumes the testbench instantiates it beside the link
`timescale 1ns/1ns
`default_nettype none
module disk_link_monitor (
  input wire logic        clk,
  input wire logic        rstn_i,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic        ext_req,
  input wire logic [2:0]  ext_idx,
  input wire logic        ext_valid,
  input wire logic        mem_valid,
  input wire logic        mem_ready,
  input wire logic [31:0] mem_addr,
  input wire logic        done,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn_i);
  // fetch, command and write handshakes
  a_ext_one_late: assert property (ext_req |=> ext_valid)
    else $error("ext answer late");
  a_ext_in_range: assert property (ext_req |-> ext_idx <= 3'h5)
    else $error("ext index past six");
  a_take_busy: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
    else $error("ready after take");
  a_cmd_holds: assert property (cmd_valid && !cmd_ready |=> cmd_valid)
    else $error("command dropped");
  a_mem_holds: assert property (mem_valid && !mem_ready |=>
    mem_valid && $stable(mem_addr)) else $error("write not held");
  // completion pulses
  a_done_drained: assert property (done |-> !mem_valid)
    else $error("done before drain");
  a_done_pulse: assert property (done |=> !done)
    else $error("done too long");
  a_irq_with_done: assert property (irq |-> done)
    else $error("irq without done");
endmodule
`default_nettype wire

// ---- disk_format_read_commands_tb.sv ----
// bench joining the host end and the controller end over the link
// assumes the design files and the monitor compile first
`timescale 1ns/1ns
`default_nettype none
module disk_format_read_commands_tb;
  logic        clk = 0, rn = 0, st = 0, sl = 0, fr = 0, dv = 0, fl = 0;
  logic        dq, di, ds, fv, fm, we, dn, iq, de = 0, ef = 0;
  logic [1:0]  j = 0;
  logic [7:0]  dd = 0, dh, dsc, fd, sc = 0, so, hd = 0, md = 0;
  logic [15:0] wd, dc, cy = 0;
  logic [31:0] wa, act, cnt = 0;
  logic [39:0] q[$];
  int          n_mismatch = 0, num_checks = 0, m = 0;
  disk_cmd_pkg::cmd_op_e op = disk_cmd_pkg::OP_READ;
  disk_cmd_if bf (.clk(clk));
  disk_host_end u_disk_host_end (.core_clk_i(clk), .rstn_i(rn), .bus(bf),
    .start_i(st), .op_i(op), .mod_i(md), .cyl_i(cy), .head_i(hd),
    .sec_i(sc), .count_i(cnt), .ext_i(48'h01d4c3b2a100), .floppy_i(fl),
    .base_i(32'h00000100), .stall_i(sl), .busy_o(), .wr_en_o(we),
    .wr_word_o(), .wr_addr_o(wa), .wr_data_o(wd), .done_o(dn), .irq_o(iq),
    .status_o(so), .actual_o(act));
  disk_ctrl_end u_disk_ctrl_end (.core_clk_i(clk), .rstn_i(rn), .bus(bf),
    .bus_width_jumper_i(fl), .buffer_mode_jumper_a_i(fl),
    .buffer_mode_jumper_b_i(fl), .floppy_i(fl),
    .sector_length_code_i(2'h0),
    .spt_i(6'h02), .heads_i(8'h02), .dk_req_o(dq), .dk_id_only_o(di),
    .dk_seek_o(ds), .dk_cyl_o(dc), .dk_head_o(dh), .dk_sec_o(dsc),
    .dk_deleted_o(), .dk_noretry_o(), .dk_valid_i(dv), .dk_data_i(dd),
    .dk_err_i(de), .fw_valid_o(fv), .fw_mark_o(fm),
    .track_kind_code_o(), .fw_data_o(fd), .fw_ready_i(fr));
  disk_link_monitor u_disk_link_monitor (.clk(clk), .rstn_i(rn),
    .cmd_valid(bf.cmd_valid), .cmd_ready(bf.cmd_ready),
    .ext_req(bf.ext_req), .ext_idx(bf.ext_idx), .ext_valid(bf.ext_valid),
    .mem_valid(bf.mem_valid), .mem_ready(bf.mem_ready),
    .mem_addr(bf.mem_addr), .done(bf.done), .irq(bf.irq));
  initial forever #20 clk = ~clk;
  // random stalls; none in read id, whose live bytes cannot wait
  always @(negedge clk) {sl, fr} = 2'($urandom)
                                   & {op != disk_cmd_pkg::OP_READ_ID, 1'b1};
  // drive model: id bytes plain, sector bytes keyed by position
  always @(posedge clk) if (dq) begin
    chk(ds === ~di, "seek flag");
    for (int i = 0; i < (di ? 5 : 128); i++) begin
      @(negedge clk);
      dv = 1;
      de = ef && i == 2;
      dd = di ? i[7:0] : i[7:0] ^ {dh[3:0], dsc[3:0]} ^ dc[7:0];
    end
    @(negedge clk);
    dv = 0;
    de = 0;
    dd = ~dd;
  end
  // each host write takes the oldest expected write
  always @(posedge clk) if (we) begin
    if (q.size() == 0) chk(1'b0, "stray write");
    else chk({wa, wd[7:0]} === q.pop_front(), "write");
  end
  // format stream: marks count up from zero, pattern bytes cycle
  always @(posedge clk) if (fv && fr) begin
    if (fm) chk(fd === m[7:0], "mark");
    else chk(fd === 8'ha1 + 8'h11 * j, "pattern");
    m = fm ? m + 1 : m;
    j = fm ? 2'h0 : j + 2'h1;
  end
  task automatic chk(input logic ok, input string s);
    num_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("BAD %0t %s", $time, s);
    end
  endtask
  task automatic run(input disk_cmd_pkg::cmd_op_e o, input logic [7:0] s,
                     input logic [31:0] c, a);
    int k;
    @(negedge clk);
    op = o;
    sc = s;
    cnt = c;
    st = 1;
    @(negedge clk);
    st = 0;
    for (k = 0; k < 20000 && dn !== 1'b1; k++) @(negedge clk);
    chk(k < 20000 && (a === '1 || act === a)
        && so === {7'h0, ef} && iq === ~md[0], "done, status or irq");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // main sequence
  initial begin
    void'($urandom(63));
    repeat (8) @(posedge clk);
    @(negedge clk);
    rn = 1;
    for (int i = 0; i < 5; i++) q.push_back({32'h100 + i, i[7:0]});
    run(disk_cmd_pkg::OP_READ_ID, 8'h00, 32'h5, '1);
    hd = 8'h01;
    cy = 16'h0005;
    for (int i = 0; i < 130; i++)
      q.push_back({32'h100 + i, i[7:0] ^ (i < 128 ? 8'h14 : 8'h86)});
    run(disk_cmd_pkg::OP_READ, 8'h01, 32'd130, 32'd130);
    md = 8'h19;
    run(disk_cmd_pkg::OP_VERIFY, 8'h00, 32'd1, 32'd128);
    md = 8'h00;
    ef = 1;
    run(disk_cmd_pkg::OP_VERIFY, 8'h00, 32'd1, 32'd0);
    ef = 0;
    run(disk_cmd_pkg::OP_FORMAT, 8'h00, 32'd0, '1);
    chk(m === 2 && q.size() === 0, "marks or writes left");
    close_out;
  end
  // watchdog against a hang
  initial begin
    #2000000;
    n_mismatch++;
    close_out;
  end
endmodule
`default_nettype wire
